// File: hdl/fvr_defines.svh
// named constants of the fault value recorder
`ifndef FVR_DEFINES_SVH
`define FVR_DEFINES_SVH
`define FVR_STAGES        4
`define FVR_OV_LO         0
`define FVR_OV_HI         1
`define FVR_UV_LO         2
`define FVR_UV_HI         3
`define FVR_DEPTH         5
`define FVR_IDX_W         3
`define FVR_V_W           16
`define FVR_PCT_W         8
`define FVR_MS_W          16
`define FVR_CNT_W         8
`define FVR_DATE_W        16
`define FVR_TIME_W        32
`define FVR_CLK_PERIOD_NS 20
`define FVR_TICK_US       1000
`define FVR_TICK_CYCLES   ((`FVR_TICK_US * 1000) / `FVR_CLK_PERIOD_NS)
`define FVR_PCT_FULL      8'h64
`define FVR_CNT_MAX       8'hFF
`define FVR_V_MIN         16'h0000
`define FVR_V_MAX         16'hFFFF
`define FVR_MS_MAX        16'hFFFF
`define FVR_NONE          4'h0
`define FVR_OV_MASK       4'h3
`define FVR_UV_MASK       4'hC
`endif

// File: hdl/fvr_pkg.sv
// types shared by the fault value recorder files
`include "fvr_defines.svh"
package fvr_pkg;
  typedef logic [`FVR_PCT_W-1:0] fvr_pct_t;

  // one stored event
  typedef struct packed {
    logic [`FVR_STAGES-1:0]  trip_mask;
    logic [`FVR_V_W-1:0]     max_v;
    logic [`FVR_V_W-1:0]     min_v;
    logic [`FVR_V_W-1:0]     min_pos_seq;
    logic [`FVR_V_W-1:0]     trip_v;
    fvr_pct_t [`FVR_STAGES-1:0] dur;
    logic [`FVR_DATE_W-1:0]  date;
    logic [`FVR_TIME_W-1:0]  tod;
  } fvr_record_t;

  // live measurement path
  typedef struct packed {
    logic [`FVR_V_W-1:0] volt;
    logic [`FVR_V_W-1:0] pos_seq;
  } fvr_meas_t;

  typedef enum logic [1:0] {
    FVR_IDLE  = 2'b00,
    FVR_TRACK = 2'b01,
    FVR_HOLD  = 2'b10
  } fvr_state_t;
endpackage

// File: hdl/fvr_event_store.sv
// five deep shifting event store with registered read port
`timescale 1ns/1ps
`include "fvr_defines.svh"
module fvr_event_store (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  // write side
  input  wire logic                   wr_en,
  input  fvr_pkg::fvr_record_t        wr_rec,
  // read side
  input  wire logic [`FVR_IDX_W-1:0]  rd_idx,
  output fvr_pkg::fvr_record_t        rd_rec_q,
  output logic                        rd_valid_q
);
  fvr_pkg::fvr_record_t          mem_q [`FVR_DEPTH];
  fvr_pkg::fvr_record_t          mem_d [`FVR_DEPTH];
  logic [`FVR_IDX_W-1:0]         fill_q;
  logic [`FVR_IDX_W-1:0]         fill_d;
  fvr_pkg::fvr_record_t          rd_rec_d;
  logic                          rd_valid_d;

  // shift toward the oldest slot, newest lands in slot 0
  always_comb begin
    for (int i = 0; i < `FVR_DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    fill_d = fill_q;
    if (wr_en) begin
      for (int i = `FVR_DEPTH - 1; i > 0; i--) begin
        mem_d[i] = mem_q[i-1];
      end
      mem_d[0] = wr_rec;
      if (fill_q != `FVR_IDX_W'(`FVR_DEPTH)) begin
        fill_d = fill_q + `FVR_IDX_W'(1);
      end
    end
    // out of range or empty slots read as zero
    rd_valid_d = (rd_idx < fill_q);
    rd_rec_d   = rd_valid_d ? mem_q[rd_idx] : '0;
  end

  // registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `FVR_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      fill_q     <= '0;
      rd_rec_q   <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      for (int i = 0; i < `FVR_DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
      fill_q     <= fill_d;
      rd_rec_q   <= rd_rec_d;
      rd_valid_q <= rd_valid_d;
    end
  end
endmodule // fvr_event_store

// File: hdl/fvr_recorder.sv
// fault value recorder for two overvoltage and two undervoltage stages
`timescale 1ns/1ps
`include "fvr_defines.svh"
module fvr_recorder #(
  parameter int TICK_CYCLES = `FVR_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            nrst,
  // protection stage status, bits 0..1 over, 2..3 under
  input  wire logic [`FVR_STAGES-1:0]          stage_start,
  input  wire logic [`FVR_STAGES-1:0]          stage_trip,
  input  wire logic [`FVR_STAGES-1:0]          idmt_mode,
  input  wire logic [`FVR_STAGES-1:0][`FVR_MS_W-1:0] set_op_ms,
  input  wire logic [`FVR_STAGES-1:0][`FVR_MS_W-1:0] calc_op_ms,
  // measurement path, scaled to rated_voltage
  input  fvr_pkg::fvr_meas_t                   meas,
  // real time clock
  input  wire logic [`FVR_DATE_W-1:0]          rtc_date,
  input  wire logic [`FVR_TIME_W-1:0]          rtc_time,
  // record readout
  input  wire logic [`FVR_IDX_W-1:0]           rd_idx,
  output fvr_pkg::fvr_record_t                 rd_rec_q,
  output logic                                 rd_valid_q,
  output logic                                 rec_stored_q,
  output logic                                 seq_busy_q,
  // start_count_params
  output logic [`FVR_STAGES-1:0][`FVR_CNT_W-1:0] start_count_q
);
  // percentage of elapsed versus operate time, capped below full
  function automatic fvr_pkg::fvr_pct_t fvr_pct(input logic [`FVR_MS_W-1:0] el,
                                                input logic [`FVR_MS_W-1:0] op);
    logic [`FVR_MS_W+6:0] prod;
    logic [`FVR_MS_W+6:0] quo;
    prod = (`FVR_MS_W+7)'(el) * (`FVR_MS_W+7)'(`FVR_PCT_FULL);
    quo  = (op == '0) ? '0 : prod / (`FVR_MS_W+7)'(op);
    // a stage that has not operated never shows full scale
    fvr_pct = (quo >= (`FVR_MS_W+7)'(`FVR_PCT_FULL)) ? `FVR_PCT_FULL - 8'h01
                                                      : quo[`FVR_PCT_W-1:0];
  endfunction

  fvr_pkg::fvr_state_t              state_q, state_d;
  logic [`FVR_STAGES-1:0]           start_prev_q, start_prev_d;
  logic [`FVR_STAGES-1:0]           contrib_q, contrib_d;
  logic [`FVR_STAGES-1:0]           trip_q, trip_d;
  logic [`FVR_STAGES-1:0][`FVR_MS_W-1:0] el_q, el_d;
  logic [`FVR_STAGES-1:0][`FVR_CNT_W-1:0] cnt_d;
  logic [`FVR_V_W-1:0]              max_v_q, max_v_d;
  logic [`FVR_V_W-1:0]              min_v_q, min_v_d;
  logic [`FVR_V_W-1:0]              min_ps_q, min_ps_d;
  logic [31:0]                      tick_cnt_q, tick_cnt_d;
  logic                             tick;
  logic                             wr_en;
  fvr_pkg::fvr_record_t             wr_rec;
  logic                             stored_d;
  logic [`FVR_STAGES-1:0]           start_rise;
  logic                             ov_on;
  logic                             uv_on;

  // millisecond enable from the system clock
  always_comb begin
    tick       = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
  end

  // start counters count rising starts, held at the top
  always_comb begin
    start_rise   = stage_start & ~start_prev_q;
    start_prev_d = stage_start;
    for (int s = 0; s < `FVR_STAGES; s++) begin
      cnt_d[s] = start_count_q[s];
      if (start_rise[s] && start_count_q[s] != `FVR_CNT_MAX) begin
        cnt_d[s] = start_count_q[s] + `FVR_CNT_W'(1);
      end
    end
  end

  // sequence tracking and record assembly
  always_comb begin
    state_d  = state_q;
    contrib_d = contrib_q;
    trip_d   = trip_q;
    el_d     = el_q;
    max_v_d  = max_v_q;
    min_v_d  = min_v_q;
    min_ps_d = min_ps_q;
    wr_en    = 1'b0;
    ov_on    = |(stage_start & `FVR_OV_MASK);
    uv_on    = |(stage_start & `FVR_UV_MASK);
    // voltages pass through unscaled, already per unit of rated_voltage
    wr_rec.trip_mask   = stage_trip & contrib_q;
    wr_rec.max_v       = max_v_q;
    wr_rec.min_v       = min_v_q;
    wr_rec.min_pos_seq = min_ps_q;
    wr_rec.trip_v      = (|(stage_trip & contrib_q)) ? meas.volt : `FVR_V_MIN;
    wr_rec.date        = rtc_date;
    wr_rec.tod         = rtc_time;
    for (int s = 0; s < `FVR_STAGES; s++) begin
      // inverse time scales against the computed operate time
      wr_rec.dur[s] = fvr_pct(el_q[s], idmt_mode[s] ? calc_op_ms[s] : set_op_ms[s]);
      if (stage_trip[s] && contrib_q[s]) begin
        wr_rec.dur[s] = `FVR_PCT_FULL;
      end
    end
    unique case (state_q)
      fvr_pkg::FVR_IDLE: begin
        if (|stage_start) begin
          state_d   = fvr_pkg::FVR_TRACK;
          contrib_d = stage_start;
          trip_d    = `FVR_NONE;
          for (int s = 0; s < `FVR_STAGES; s++) begin
            el_d[s] = '0;
          end
          max_v_d  = ov_on ? meas.volt : `FVR_V_MIN;
          min_v_d  = uv_on ? meas.volt : `FVR_V_MAX;
          min_ps_d = uv_on ? meas.pos_seq : `FVR_V_MAX;
        end
      end
      fvr_pkg::FVR_TRACK: begin
        contrib_d = contrib_q | stage_start;
        for (int s = 0; s < `FVR_STAGES; s++) begin
          if (stage_start[s] && tick && el_q[s] != `FVR_MS_MAX) begin
            el_d[s] = el_q[s] + `FVR_MS_W'(1);
          end
        end
        if (ov_on && meas.volt > max_v_q) begin
          max_v_d = meas.volt;
        end
        if (uv_on && meas.volt < min_v_q) begin
          min_v_d = meas.volt;
        end
        if (uv_on && meas.pos_seq < min_ps_q) begin
          min_ps_d = meas.pos_seq;
        end
        if (|(stage_trip & contrib_q)) begin
          // trip values and start-period values go out together
          wr_en   = 1'b1;
          trip_d  = stage_trip & contrib_q;
          state_d = fvr_pkg::FVR_HOLD;
        end else if ((contrib_q & stage_start) == `FVR_NONE) begin
          wr_en   = 1'b1;
          state_d = fvr_pkg::FVR_IDLE;
        end
      end
      fvr_pkg::FVR_HOLD: begin
        // wait for every stage of this sequence to drop out
        if ((contrib_q & (stage_start | stage_trip)) == `FVR_NONE) begin
          state_d = fvr_pkg::FVR_IDLE;
        end
      end
      default: begin
        state_d = fvr_pkg::FVR_IDLE;
      end
    endcase
    stored_d = wr_en;
  end

  // registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q       <= fvr_pkg::FVR_IDLE;
      start_prev_q  <= `FVR_NONE;
      contrib_q     <= `FVR_NONE;
      trip_q        <= `FVR_NONE;
      el_q          <= '0;
      start_count_q <= '0;
      max_v_q       <= `FVR_V_MIN;
      min_v_q       <= `FVR_V_MAX;
      min_ps_q      <= `FVR_V_MAX;
      tick_cnt_q    <= 32'h0000_0000;
      rec_stored_q  <= 1'b0;
      seq_busy_q    <= 1'b0;
    end else begin
      state_q       <= state_d;
      start_prev_q  <= start_prev_d;
      contrib_q     <= contrib_d;
      trip_q        <= trip_d;
      el_q          <= el_d;
      start_count_q <= cnt_d;
      max_v_q       <= max_v_d;
      min_v_q       <= min_v_d;
      min_ps_q      <= min_ps_d;
      tick_cnt_q    <= tick_cnt_d;
      rec_stored_q  <= stored_d;
      seq_busy_q    <= (state_d != fvr_pkg::FVR_IDLE);
    end
  end

  // five deep history
  fvr_event_store u_store (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .wr_en      (wr_en),
    .wr_rec     (wr_rec),
    .rd_idx     (rd_idx),
    .rd_rec_q   (rd_rec_q),
    .rd_valid_q (rd_valid_q)
  );
endmodule // fvr_recorder

// File: verification/fvr_recorder_assertions.sv
// port assertions for the fault value recorder
`timescale 1ns/1ps
module fvr_recorder_assertions (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            nrst,
  // watched ports
  input wire logic [3:0]      stage_start,
  input wire logic [2:0]      rd_idx,
  input fvr_pkg::fvr_record_t rd_rec_q,
  input wire logic            rd_valid_q,
  input wire logic            rec_stored_q,
  input wire logic            seq_busy_q,
  input wire logic [3:0][7:0] start_count_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // store strobe and sequence state
  a_pulse_single: assert property (rec_stored_q |=> !rec_stored_q)
    else $error("store pulse longer than one cycle");
  a_store_busy: assert property (rec_stored_q |-> $past(seq_busy_q))
    else $error("record stored outside a sequence");
  a_start_opens: assert property (!seq_busy_q && |stage_start |=> seq_busy_q)
    else $error("start did not open a sequence");
  // start counters, stage 3 is pushed to saturation by the bench
  a_count_step: assert property ($rose(stage_start[3]) && start_count_q[3] != 8'hFF
    |=> start_count_q[3] == $past(start_count_q[3]) + 8'h01)
    else $error("start counter did not step");
  a_count_sat: assert property (start_count_q[3] == 8'hFF |=> start_count_q[3] == 8'hFF)
    else $error("start counter wrapped");
  a_count_quiet: assert property (!$rose(stage_start[0]) |=> $stable(start_count_q[0]))
    else $error("start counter moved without a start");
  // readout
  a_newest_valid: assert property (rec_stored_q && rd_idx == 3'h0 |=> rd_valid_q)
    else $error("newest slot not valid after store");
  a_out_range: assert property (rd_idx > 3'h4 |=> !rd_valid_q && rd_rec_q == '0)
    else $error("slot beyond depth reads a record");
  a_full_trip: assert property (rd_valid_q |->
    rd_rec_q.trip_mask[0] == (rd_rec_q.dur[0] == 8'h64))
    else $error("trip and full duration disagree");
  c_store: cover property ($rose(rec_stored_q));
  c_sat: cover property (start_count_q[3] == 8'hFF);
  c_trip: cover property (rd_valid_q && rd_rec_q.trip_mask != 4'h0);
endmodule // fvr_recorder_assertions

// File: verification/fvr_recorder_bench.sv
// self-checking bench for the fault value recorder
`timescale 1ns/1ps
module fvr_recorder_bench;
  logic                 sys_clk, nrst, rd_valid_q, rec_stored_q, seq_busy_q;
  logic [3:0]           stage_start, stage_trip, idmt_mode;
  logic [3:0][15:0]     set_op_ms, calc_op_ms;
  fvr_pkg::fvr_meas_t   meas;
  logic [15:0]          rtc_date;
  logic [31:0]          rtc_time, rs;
  logic [2:0]           rd_idx;
  logic [3:0][7:0]      start_count_q;
  fvr_pkg::fvr_record_t rd_rec_q, e, model_q[$];
  int                   fails, checked, cnt[4];

  fvr_recorder #(.TICK_CYCLES(10)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .stage_start(stage_start), .stage_trip(stage_trip), .idmt_mode(idmt_mode),
    .set_op_ms(set_op_ms), .calc_op_ms(calc_op_ms), .meas(meas), .rtc_date(rtc_date),
    .rtc_time(rtc_time), .rd_idx(rd_idx), .rd_rec_q(rd_rec_q), .rd_valid_q(rd_valid_q),
    .rec_stored_q(rec_stored_q), .seq_busy_q(seq_busy_q), .start_count_q(start_count_q));

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // walk every slot, beyond the depth too, against the model
  task automatic readback();
    for (int i = 0; i < 8; i++) begin
      rd_idx = i[2:0];
      @(negedge sys_clk);
      e = (i < model_q.size()) ? model_q[i] : '0;
      chk("valid", rd_valid_q, i < model_q.size());
      chk("mask", rd_rec_q.trip_mask, e.trip_mask);
      chk("max", rd_rec_q.max_v, e.max_v);
      chk("min", rd_rec_q.min_v, e.min_v);
      chk("pos", rd_rec_q.min_pos_seq, e.min_pos_seq);
      chk("dur", rd_rec_q.dur, e.dur);
      chk("stamp", {rd_rec_q.date, rd_rec_q.tod}, {e.date, e.tod});
      chk("tripv", rd_rec_q.trip_v, e.trip_v);
    end
    for (int s = 0; s < 4; s++) chk("count", start_count_q[s], cnt[s]);
  endtask

  // one start sequence on stage s, called and left at a falling edge
  task automatic run_seq(int s, bit trip);
    int k;
    logic [31:0] r;
    bit ov;
    ov = s < 2;
    k = rnd() % 3;
    e = '0;
    e.min_v = 16'hFFFF;
    e.min_pos_seq = 16'hFFFF;
    {rtc_date, rtc_time} = {rnd(), rnd()};
    {e.date, e.tod} = {rtc_date, rtc_time};
    idmt_mode = (k == 1) ? 4'h1 << s : 4'h0;
    set_op_ms = '0;
    set_op_ms[s] = (k != 0) ? 16'h0001 : 16'h0000;
    calc_op_ms = '0;
    e.dur[s] = (k == 2) ? 8'h63 : 8'h00;
    cnt[s] = (cnt[s] < 255) ? cnt[s] + 1 : 255;
    for (int i = 0; i < 25 + rnd() % 10; i++) begin
      r = rnd();
      meas = r;
      stage_start[s] = 1'b1;
      if (ov && meas.volt > e.max_v) e.max_v = meas.volt;
      if (!ov && meas.volt < e.min_v) e.min_v = meas.volt;
      if (!ov && meas.pos_seq < e.min_pos_seq) e.min_pos_seq = meas.pos_seq;
      @(negedge sys_clk);
    end
    // neutral level that cannot move the trackers
    meas = ov ? {e.max_v >> 1, 16'h0000} : 32'hFFFE_FFFF;
    if (trip) begin
      stage_trip[s] = 1'b1;
      e.trip_mask[s] = 1'b1;
      e.trip_v = meas.volt;
      e.dur[s] = 8'h64;
    end else stage_start[s] = 1'b0;
    for (int j = 0; j < 5 && rec_stored_q !== 1'b1; j++) @(negedge sys_clk);
    chk("stored", rec_stored_q, 1);
    if (trip) begin
      stage_start[s ^ 1] = 1'b1;
      cnt[s ^ 1] = (cnt[s ^ 1] < 255) ? cnt[s ^ 1] + 1 : 255;
      repeat (3) @(negedge sys_clk);
      chk("hold", {seq_busy_q, rec_stored_q}, 2'b10);
      stage_start = 4'h0;
      stage_trip = 4'h0;
      repeat (2) @(negedge sys_clk);
    end
    model_q.push_front(e);
    if (model_q.size() > 5) void'(model_q.pop_back());
    readback();
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // run ends by itself near 16k cycles, so 50k cycles means a hang
  initial begin
    #1000000;
    fails++;
    results();
  end

  initial begin
    rs = 32'h6D1F;
    {nrst, stage_start, stage_trip, idmt_mode, rd_idx} = '0;
    {set_op_ms, calc_op_ms, meas, rtc_date, rtc_time} = '0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    readback();
    // stage 3 gets most sequences so its counter saturates
    for (int it = 0; it < 400; it++) begin
      // late mid-run reset, after stage 3 has saturated, must empty store and counters
      if (it == 380) begin
        nrst = 1'b0;
        model_q.delete();
        foreach (cnt[s]) cnt[s] = 0;
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        readback();
      end
      run_seq((it % 3 != 0) ? 3 : rnd() % 4, rnd() % 2);
    end
    results();
  end
endmodule // fvr_recorder_bench

bind fvr_recorder fvr_recorder_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .stage_start(stage_start), .rd_idx(rd_idx), .rd_rec_q(rd_rec_q), .rd_valid_q(rd_valid_q),
  .rec_stored_q(rec_stored_q), .seq_busy_q(seq_busy_q), .start_count_q(start_count_q));
